//--- bist_mask_pkg.sv
// Shared constants for the self-test fault mask register bank
package bist_mask_pkg;
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 8;
	localparam int          MUX_CHANNELS   = 6;
	localparam logic [7:0]  ADDR_VOLT_MASK = 8'h19;
	localparam logic [7:0]  ADDR_TEMP_MASK = 8'h1A;
	localparam logic [7:0]  ADDR_SCRATCH   = 8'h1B;
	localparam logic [7:0]  ADDR_STATUS    = 8'h20;
	localparam logic [7:0]  ADDR_STAT_TEMP = 8'h21;
	localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h22;
	localparam logic [7:0]  ADDR_IRQ_MTEMP = 8'h23;
	localparam logic [7:0]  RESET_VALUE    = 8'h00;
	localparam int          VOLT_UV_BIT    = 0;
	localparam int          VOLT_OV_BIT    = 1;
	localparam int          TEMP_OT_BIT    = 0;
	localparam int          TEMP_UT_BIT    = 1;
	localparam int          TEMP_MUX_LSB   = 2;
endpackage : bist_mask_pkg

//--- protector_bist_fault_mask_regs.sv
// Self-test fault mask registers with fault status and interrupt
//
// Added by the designer: the address-and-strobe port.
module protector_bist_fault_mask_regs
(
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [7:0]  rdata,
	input  wire logic        high_voltage_check_fault,
	input  wire logic        low_voltage_check_fault,
	input  wire logic        hot_check_fault,
	input  wire logic        cold_check_fault,
	input  wire logic [5:0]  thermistor_fault,
	output logic             voltage_fault_signal,
	output logic             temperature_fault_signal,
	output logic      [1:0]  voltage_fault_out,
	output logic      [7:0]  temperature_fault_out,
	output logic             irq
);
	logic       rst_meta_n;
	logic       rst_n;
	logic [9:0] fault_meta;
	logic [9:0] fault_sync;

	logic [7:0] voltage_selftest_fault_mask;
	logic [7:0] temperature_selftest_fault_mask;
	logic [7:0] factory_error_scratch_one;
	logic [1:0] voltage_selftest_fault_status;
	logic [7:0] temperature_selftest_fault_status;
	logic [1:0] irq_mask_volt;
	logic [7:0] irq_mask_temp;

	logic [7:0] next_volt_mask;
	logic [7:0] next_temp_mask;
	logic [7:0] next_scratch;
	logic [1:0] next_volt_stat;
	logic [7:0] next_temp_stat;
	logic [1:0] next_irq_mask_volt;
	logic [7:0] next_irq_mask_temp;
	logic [7:0] next_rdata;
	logic [1:0] next_volt_out;
	logic [7:0] next_temp_out;
	logic       next_irq;

	logic [1:0] volt_raw;
	logic [7:0] temp_raw;
	logic [7:0] temp_block;
	logic [1:0] volt_block;
	logic       wr_volt_mask;
	logic       wr_temp_mask;
	logic       wr_scratch;
	logic       wr_volt_stat;
	logic       wr_temp_stat;
	logic       wr_irq_volt;
	logic       wr_irq_temp;
	logic       next_volt_sig;
	logic       next_temp_sig;

	// Two voltage bits below eight temperature bits share one gate loop
	localparam int GATE_BITS = bist_mask_pkg::DATA_W + 2;
	logic [GATE_BITS-1:0] gate_stat;
	logic [GATE_BITS-1:0] gate_block;
	logic [GATE_BITS-1:0] next_gate_out;

	// Reset release synchroniser
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	// Fault inputs come from analog comparators, so synchronise them
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fault_meta <= 10'h000;
			fault_sync <= 10'h000;
		end
		else
		begin
			fault_meta <= {thermistor_fault, low_voltage_check_fault,
				high_voltage_check_fault, hot_check_fault,
				cold_check_fault};
			fault_sync <= fault_meta;
		end
	end

	// Map the synchronised pins onto the status bit layout
	always_comb
	begin
		volt_raw = 2'h0;
		temp_raw = 8'h00;
		volt_raw[bist_mask_pkg::VOLT_OV_BIT] = fault_sync[2];
		volt_raw[bist_mask_pkg::VOLT_UV_BIT] = fault_sync[3];
		temp_raw[bist_mask_pkg::TEMP_OT_BIT] = fault_sync[1];
		temp_raw[bist_mask_pkg::TEMP_UT_BIT] = fault_sync[0];
		temp_raw[7:bist_mask_pkg::TEMP_MUX_LSB] = fault_sync[9:4];
	end

	// Only the low two voltage mask bits gate; spare bits stay out of the path
	assign volt_block = voltage_selftest_fault_mask[1:0];
	assign temp_block = temperature_selftest_fault_mask;

	// Write decode: one strobe per register, never two at once
	always_comb
	begin
		wr_volt_mask = wr_en && (addr == bist_mask_pkg::ADDR_VOLT_MASK);
		wr_temp_mask = wr_en && (addr == bist_mask_pkg::ADDR_TEMP_MASK);
		wr_scratch   = wr_en && (addr == bist_mask_pkg::ADDR_SCRATCH);
		wr_volt_stat = wr_en && (addr == bist_mask_pkg::ADDR_STATUS);
		wr_temp_stat = wr_en && (addr == bist_mask_pkg::ADDR_STAT_TEMP);
		wr_irq_volt  = wr_en && (addr == bist_mask_pkg::ADDR_IRQ_MASK);
		wr_irq_temp  = wr_en && (addr == bist_mask_pkg::ADDR_IRQ_MTEMP);
	end

	// Masks and scratch are plain storage with no side effects
	always_comb
	begin
		next_volt_mask = voltage_selftest_fault_mask;
		next_temp_mask = temperature_selftest_fault_mask;
		next_scratch   = factory_error_scratch_one;
		if (wr_volt_mask)
		begin
			next_volt_mask = wdata;
		end
		if (wr_temp_mask)
		begin
			next_temp_mask = wdata;
		end
		if (wr_scratch)
		begin
			next_scratch = wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			voltage_selftest_fault_mask     <= bist_mask_pkg::RESET_VALUE;
			temperature_selftest_fault_mask <= bist_mask_pkg::RESET_VALUE;
			factory_error_scratch_one       <= bist_mask_pkg::RESET_VALUE;
		end
		else
		begin
			voltage_selftest_fault_mask     <= next_volt_mask;
			temperature_selftest_fault_mask <= next_temp_mask;
			factory_error_scratch_one       <= next_scratch;
		end
	end

	// Sticky status; a new fault wins over a clear in the same cycle
	always_comb
	begin
		next_volt_stat = voltage_selftest_fault_status;
		next_temp_stat = temperature_selftest_fault_status;
		if (wr_volt_stat)
		begin
			next_volt_stat = next_volt_stat & ~wdata[1:0];
		end
		if (wr_temp_stat)
		begin
			next_temp_stat = next_temp_stat & ~wdata;
		end
		// Recording ignores the masks so software still sees the cause
		next_volt_stat = next_volt_stat | volt_raw;
		next_temp_stat = next_temp_stat | temp_raw;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			voltage_selftest_fault_status <= bist_mask_pkg::RESET_VALUE[1:0];
			temperature_selftest_fault_status <= bist_mask_pkg::RESET_VALUE;
		end
		else
		begin
			voltage_selftest_fault_status     <= next_volt_stat;
			temperature_selftest_fault_status <= next_temp_stat;
		end
	end

	// Interrupt enables: 1 lets a signalled fault reach irq
	always_comb
	begin
		next_irq_mask_volt = irq_mask_volt;
		next_irq_mask_temp = irq_mask_temp;
		if (wr_irq_volt)
		begin
			next_irq_mask_volt = wdata[1:0];
		end
		if (wr_irq_temp)
		begin
			next_irq_mask_temp = wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_mask_volt <= bist_mask_pkg::RESET_VALUE[1:0];
			irq_mask_temp <= bist_mask_pkg::RESET_VALUE;
		end
		else
		begin
			irq_mask_volt <= next_irq_mask_volt;
			irq_mask_temp <= next_irq_mask_temp;
		end
	end

	// Read data stands for one cycle, zero otherwise
	always_comb
	begin
		next_rdata = 8'h00;
		if (rd_en)
		begin
			unique case (addr)
				bist_mask_pkg::ADDR_VOLT_MASK:
					next_rdata = voltage_selftest_fault_mask;
				bist_mask_pkg::ADDR_TEMP_MASK:
					next_rdata = temperature_selftest_fault_mask;
				bist_mask_pkg::ADDR_SCRATCH:
					next_rdata = factory_error_scratch_one;
				bist_mask_pkg::ADDR_STATUS:
					next_rdata = {6'h00, voltage_selftest_fault_status};
				bist_mask_pkg::ADDR_STAT_TEMP:
					next_rdata = temperature_selftest_fault_status;
				bist_mask_pkg::ADDR_IRQ_MASK:
					next_rdata = {6'h00, irq_mask_volt};
				bist_mask_pkg::ADDR_IRQ_MTEMP:
					next_rdata = irq_mask_temp;
				// Unmapped reads return zero rather than stale data
				default:
					next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata <= bist_mask_pkg::RESET_VALUE;
		end
		else
		begin
			rdata <= next_rdata;
		end
	end

	// One gate per status bit; voltage bits sit below temperature bits
	assign gate_stat  = {temperature_selftest_fault_status,
		voltage_selftest_fault_status};
	assign gate_block = {temp_block, volt_block};
	for (genvar idx = 0; idx < GATE_BITS; idx++)
	begin : gen_gate
		assign next_gate_out[idx] = gate_stat[idx] & ~gate_block[idx];
	end
	assign next_volt_out = next_gate_out[1:0];
	assign next_temp_out = next_gate_out[9:2];

	// Interrupt only sees faults that survive the block mask
	always_comb
	begin
		next_volt_sig = |next_volt_out;
		next_temp_sig = |next_temp_out;
		next_irq      = |(next_volt_out & irq_mask_volt) |
			|(next_temp_out & irq_mask_temp);
	end

	// Outputs come straight from flops so pins never glitch
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			voltage_fault_out        <= bist_mask_pkg::RESET_VALUE[1:0];
			temperature_fault_out    <= bist_mask_pkg::RESET_VALUE;
			voltage_fault_signal     <= 1'b0;
			temperature_fault_signal <= 1'b0;
			irq                      <= 1'b0;
		end
		else
		begin
			voltage_fault_out        <= next_volt_out;
			temperature_fault_out    <= next_temp_out;
			voltage_fault_signal     <= next_volt_sig;
			temperature_fault_signal <= next_temp_sig;
			irq                      <= next_irq;
		end
	end
endmodule : protector_bist_fault_mask_regs

//--- bist_mask_props.sv
// Port assertions for the self-test fault mask bank
module bist_mask_props
(
	input wire logic       ref_clk,
	input wire logic       arst_n,
	input wire logic       rd_en,
	input wire logic [7:0] rdata,
	input wire logic       high_voltage_check_fault,
	input wire logic       low_voltage_check_fault,
	input wire logic       hot_check_fault,
	input wire logic       cold_check_fault,
	input wire logic [5:0] thermistor_fault,
	input wire logic       voltage_fault_signal,
	input wire logic       temperature_fault_signal,
	input wire logic [1:0] voltage_fault_out,
	input wire logic [7:0] temperature_fault_out
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
		else $error("rdata set outside read");
	a_volt_or: assert property (
		voltage_fault_signal == |voltage_fault_out)
		else $error("voltage signal wrong");
	a_temp_or: assert property (
		temperature_fault_signal == |temperature_fault_out)
		else $error("temperature signal wrong");
	// Rises only three edges after the raw fault, never from a spare bit
	a_ov_cause: assert property (
		$rose(voltage_fault_out[1]) |->
		$past(high_voltage_check_fault, 3))
		else $error("ov out without fault");
	a_uv_cause: assert property (
		$rose(voltage_fault_out[0]) |->
		$past(low_voltage_check_fault, 3))
		else $error("uv out without fault");
	a_hot_cause: assert property (
		$rose(temperature_fault_out[0]) |->
		$past(hot_check_fault, 3))
		else $error("hot out without fault");
	a_cold_cause: assert property (
		$rose(temperature_fault_out[1]) |->
		$past(cold_check_fault, 3))
		else $error("cold out without fault");
	a_mux_cause: assert property (
		(temperature_fault_out[7:2] &
		~$past(temperature_fault_out[7:2]) &
		~$past(thermistor_fault, 3)) == 6'h00)
		else $error("mux out without fault");
endmodule : bist_mask_props

bind protector_bist_fault_mask_regs bist_mask_props props (.ref_clk(ref_clk),
	.arst_n(arst_n), .rd_en(rd_en), .rdata(rdata),
	.high_voltage_check_fault(high_voltage_check_fault),
	.low_voltage_check_fault(low_voltage_check_fault),
	.hot_check_fault(hot_check_fault), .cold_check_fault(cold_check_fault),
	.thermistor_fault(thermistor_fault),
	.voltage_fault_signal(voltage_fault_signal),
	.temperature_fault_signal(temperature_fault_signal),
	.voltage_fault_out(voltage_fault_out),
	.temperature_fault_out(temperature_fault_out));

//--- testbench.sv
// Self-checking bench for the fault mask register bank
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk = 0;
	logic       arst_n = 0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 0;
	logic       rd_en = 0;
	logic [7:0] rdata;
	logic [3:0] raw = 4'h0;
	logic [5:0] therm = 6'h00;
	logic       vsig;
	logic       tsig;
	logic [1:0] vout;
	logic [7:0] tout;
	logic       irq;
	int         n_fail = 0;
	int         checked = 0;
	always #5 ref_clk = ~ref_clk;
	protector_bist_fault_mask_regs uut (.ref_clk(ref_clk), .arst_n(arst_n),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .high_voltage_check_fault(raw[3]),
		.low_voltage_check_fault(raw[2]), .hot_check_fault(raw[1]),
		.cold_check_fault(raw[0]), .thermistor_fault(therm),
		.voltage_fault_signal(vsig), .temperature_fault_signal(tsig),
		.voltage_fault_out(vout), .temperature_fault_out(tout), .irq(irq));
	task automatic chk(input logic [7:0] seen, exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask : wr
	// Read data stands one cycle only; the next edge still sees it
	task automatic rd(input logic [7:0] a, exp);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		@(posedge ref_clk);
		chk(rdata, exp, "rdata");
	endtask : rd
	task automatic settle;
		repeat (5) @(posedge ref_clk);
	endtask : settle
	task automatic end_sim;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	initial
	begin
		#20us;
		n_fail++;
		end_sim;
	end
	initial
	begin
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(8'h19, 8'h00);
		rd(8'h1A, 8'h00);
		rd(8'h1B, 8'h00);
		wr(8'h19, 8'hFE);
		wr(8'h1A, 8'hAA);
		wr(8'h1B, 8'h3C);
		wr(8'h30, 8'hFF);
		rd(8'h19, 8'hFE);
		rd(8'h1A, 8'hAA);
		rd(8'h1B, 8'h3C);
		rd(8'h30, 8'h00);
		$display("register test done");
		raw <= 4'hF;
		therm <= 6'h3F;
		settle;
		chk({6'h00, vout}, 8'h01, "vout");
		chk(tout, 8'h55, "tout");
		rd(8'h20, 8'h03);
		rd(8'h21, 8'hFF);
		wr(8'h22, 8'h01);
		settle;
		chk({7'h00, irq}, 8'h01, "irq");
		wr(8'h22, 8'h00);
		settle;
		chk({7'h00, irq}, 8'h00, "irq");
		wr(8'h22, 8'h01);
		raw <= 4'h0;
		therm <= 6'h00;
		// Let the cleared pins reach status so the clear is not overridden
		settle;
		wr(8'h20, 8'hFF);
		wr(8'h21, 8'hFF);
		settle;
		chk({irq, vsig, tsig, 5'h00}, 8'h00, "irq sig");
		$display("mask test one done");
		wr(8'h19, 8'h01);
		wr(8'h1A, 8'h55);
		raw <= 4'hF;
		therm <= 6'h3F;
		settle;
		chk({6'h00, vout}, 8'h02, "vout");
		chk(tout, 8'hAA, "tout");
		chk({6'h00, vsig, tsig}, 8'h03, "sig");
		chk({7'h00, irq}, 8'h00, "irq");
		wr(8'h20, 8'hFF);
		rd(8'h20, 8'h03);
		$display("mask test two done");
		rd(8'h22, 8'h01);
		wr(8'h23, 8'h80);
		rd(8'h23, 8'h80);
		settle;
		chk({7'h00, irq}, 8'h01, "irq");
		wr(8'h23, 8'h04);
		settle;
		chk({7'h00, irq}, 8'h00, "irq");
		$display("irq test done");
		end_sim;
	end
endmodule : testbench
